// *** verilog/mfr_ctrl.sv ***
// Top: fault response controller with Wishbone register slave and gate drive gating
//
// Operation
// R1 - Main-supply undervoltage response follows stop-on-fault bit
// R2 - Stop-on-fault: main undervoltage turns off all gates
// R3 - Auto restart: restart when main undervoltage clears
// R4 - No auto restart: stay stopped until clearing event
// R5 - Host demand reset: zero then new nonzero
// R6 - Host run reset: write run zero then one
// R7 - Stop-on-fault: short, bootstrap, overtemperature stop all
// R8 - Stop-on-fault: short/bootstrap latch until clearing event
// R9 - Overtemperature: keep gates off 10 ms more
// R10 - No stop-on-fault: overtemperature takes no action
// R11 - No stop-on-fault: short/bootstrap turns off one transistor
// R12 - Single transistor stays off until next on-period
// R13 - Full disable forces every gate drive low
// R14 - Serial clear only when read-clear inhibit is zero
// R15 - Regulator/watchdog faults: reset host, latch, watchdog release
// R16 - Stop-on-fault overtemperature: regulator off, host reset
// R17 - Power-on reset clears every latched fault
// R18 - Fault flags clear only by reset or read
// R19 - Sync loss with auto restart: stop, start again
// R20 - Gate disable is OR of full-shutdown states
`timescale 1ns/10ps
`default_nettype none
module mfr_ctrl #(
    parameter logic [mfr_pkg::TMR_W-1:0] OT_HOLD_CYCLES   = mfr_pkg::OT_HOLD_CYC,
    parameter logic [mfr_pkg::TMR_W-1:0] WD_WINDOW_CYCLES = mfr_pkg::WD_WINDOW_CYC
) (
    // Clock and power-on reset
    input  wire logic                            clock,
    input  wire logic                            rstn,
    // Wishbone slave
    input  wire logic                            wb_cyc_i,
    input  wire logic                            wb_stb_i,
    input  wire logic                            wb_we_i,
    input  wire logic [mfr_pkg::ADR_W-1:0]       wb_adr_i,
    input  wire logic [3:0]                      wb_sel_i,
    input  wire logic [mfr_pkg::DAT_W-1:0]       wb_dat_i,
    output logic                                 wb_ack_o,
    output logic [mfr_pkg::DAT_W-1:0]            wb_dat_o,
    // Fault detectors
    input  wire logic                            main_supply_uv,
    input  wire logic                            logic_regulator_uv,
    input  wire logic                            watchdog_fault,
    input  wire logic                            over_temp,
    input  wire logic                            sync_loss,
    input  wire logic [mfr_pkg::NUM_FET-1:0]     drain_source_monitor,
    input  wire logic [mfr_pkg::NUM_FET-1:0]     bootstrap_uv,
    // Host side pins
    input  wire logic [mfr_pkg::DEMAND_W-1:0]    speed_demand,
    input  wire logic                            watchdog_in,
    output logic                                 host_reset_out_n,
    // Bridge drive
    input  wire logic [mfr_pkg::NUM_FET-1:0]     gate_cmd,
    input  wire logic [mfr_pkg::NUM_FET-1:0]     pwm_on_start,
    output logic [mfr_pkg::NUM_FET-1:0]          gate_out,
    output logic                                 gate_disable,
    output logic                                 logic_regulator_off,
    output logic                                 restart_req
);
    import mfr_pkg::*;

    mfr_state_t q;
    mfr_state_t next_q;

    mfr_tmr_if ot_tif ();
    mfr_tmr_if wd_tif ();

    mfr_timer #(
        .LIMIT (OT_HOLD_CYCLES)
    ) u_ot_timer (
        .clock (clock),
        .rstn  (rstn),
        .tif   (ot_tif.tmr)
    );

    mfr_timer #(
        .LIMIT (WD_WINDOW_CYCLES)
    ) u_wd_timer (
        .clock (clock),
        .rstn  (rstn),
        .tif   (wd_tif.tmr)
    );

    assign ot_tif.run = q.ot_hold;
    // Window opens only once the host reset has been released
    assign wd_tif.run = q.crit_lat & q.host_reset_out_n;

    function automatic logic [DAT_W-1:0] read_mux(input logic [ADR_W-1:0] adr,
                                                  input mfr_state_t s);
        logic [DAT_W-1:0] d;
        d = '0;
        case (adr)
            ADR_CTRL: begin
                d[CTRL_W-1:0] = s.ctrl;
            end
            ADR_STATUS: begin
                d[ST_W-1:0] = s.st_flags;
            end
            ADR_DIAG: begin
                d[DG_SHORT_LSB +: NUM_FET] = s.short_flags;
                d[DG_BOOT_LSB +: NUM_FET]  = s.boot_flags;
            end
            ADR_STATE: begin
                d[NUM_FET-1:0]         = s.sb_lat;
                d[NUM_FET +: NUM_FET]  = s.fet_off;
                d[2*NUM_FET]           = s.main_uv_lat;
                d[2*NUM_FET+1]         = s.sync_lat;
                d[2*NUM_FET+2]         = s.ot_hold;
                d[2*NUM_FET+3]         = s.crit_lat;
                d[2*NUM_FET+4]         = s.host_reset_out_n;
                d[2*NUM_FET+5]         = s.gate_disable;
            end
            default: begin
                d = '0;
            end
        endcase
        return d;
    endfunction

    // Read-clear strobe for one register; the inhibit bit blocks it
    function automatic logic serial_clear(input logic             rd_ack,
                                          input logic [ADR_W-1:0] adr,
                                          input logic [ADR_W-1:0] target,
                                          input logic             inhibit);
        return rd_ack & (adr == target) & ~inhibit;
    endfunction

    // Fault levels placed at their status register positions
    function automatic logic [ST_W-1:0] status_events(input logic main_uv,
                                                      input logic lr_uv,
                                                      input logic wd_fault,
                                                      input logic ot,
                                                      input logic sync);
        logic [ST_W-1:0] e;
        e             = '0;
        e[ST_MAIN_UV] = main_uv;
        e[ST_LR_UV]   = lr_uv;
        e[ST_WD]      = wd_fault;
        e[ST_OT]      = ot;
        e[ST_SYNC]    = sync;
        return e;
    endfunction

    // Sticky per-transistor flags; a new event beats a read clear
    function automatic logic [NUM_FET-1:0] sticky_fet(input logic [NUM_FET-1:0] old,
                                                      input logic               clr,
                                                      input logic [NUM_FET-1:0] evt);
        return (clr ? '0 : old) | evt;
    endfunction

    logic                stop_en;
    logic                restart_en;
    logic                bus_req;
    logic                bus_done;
    logic                wr;
    logic                wr_ctrl;
    logic                rd;
    logic                rd_clr_st;
    logic                rd_clr_dg;
    logic                demand_reset;
    logic                run_reset;
    logic                user_clr;
    logic                ot_active;
    logic                crit_now;
    logic                wd_edge;
    logic                full_off;
    logic [NUM_FET-1:0]  sb_fault;

    always_comb begin
        next_q = q;
        stop_en    = q.ctrl[CTRL_STOP_EN];
        restart_en = q.ctrl[CTRL_RESTART];

        // Ack one cycle after the request; effects land on the ack edge
        bus_req  = wb_cyc_i & wb_stb_i & ~q.wb_ack;
        bus_done = wb_cyc_i & wb_stb_i & q.wb_ack;
        wr       = bus_done & wb_we_i;
        rd       = bus_done & ~wb_we_i;
        next_q.wb_ack = bus_req;
        if (bus_req) begin
            next_q.wb_dat = read_mux(wb_adr_i, q);
        end else begin
            next_q.wb_dat = '0;
        end
        // Clear on the ack edge, so the word already sent still shows the flags
        rd_clr_st = serial_clear(rd, wb_adr_i, ADR_STATUS, q.ctrl[CTRL_INH]); // R14
        rd_clr_dg = serial_clear(rd, wb_adr_i, ADR_DIAG, q.ctrl[CTRL_INH]);   // R14
        // Only byte lane 0 carries control bits
        wr_ctrl   = wr & (wb_adr_i == ADR_CTRL) & wb_sel_i[0];
        if (wr_ctrl) begin
            next_q.ctrl = wb_dat_i[CTRL_W-1:0];
        end

        // Run bit written low then high; demand to zero then nonzero
        run_reset = ~q.ctrl[CTRL_RUN] & next_q.ctrl[CTRL_RUN];    // R6
        demand_reset = q.demand_zero_seen & (speed_demand != '0); // R5
        if (speed_demand == '0) begin
            next_q.demand_zero_seen = 1'b1;
        end else if (demand_reset) begin
            next_q.demand_zero_seen = 1'b0;
        end
        user_clr = run_reset | demand_reset;

        next_q.restart_req = 1'b0;
        next_q.main_uv_d   = main_supply_uv;
        next_q.sync_d      = sync_loss;
        next_q.ot_d        = over_temp;
        next_q.wd_d        = watchdog_in;

        // Main supply undervoltage: clear first so a new set wins
        if (user_clr || rd_clr_st) begin
            next_q.main_uv_lat = 1'b0; // R4
        end
        if (stop_en && !restart_en && main_supply_uv) begin
            next_q.main_uv_lat = 1'b1; // R4 R1
        end
        if (stop_en && restart_en && q.main_uv_d && !main_supply_uv) begin
            next_q.restart_req = 1'b1; // R3
        end

        // Loss of synchronisation
        if (user_clr || rd_clr_st) begin
            next_q.sync_lat = 1'b0;
        end
        if (sync_loss && !restart_en) begin
            next_q.sync_lat = 1'b1;
        end
        // Auto restart never latches; the startup sequence takes over
        if (sync_loss && !q.sync_d && restart_en) begin
            next_q.restart_req = 1'b1; // R19
        end

        // Shorts and bootstrap undervoltage
        sb_fault = drain_source_monitor | bootstrap_uv;
        if (user_clr || rd_clr_dg) begin
            next_q.sb_lat = '0; // R8
        end
        if (stop_en) begin
            next_q.sb_lat = next_q.sb_lat | sb_fault; // R7 R8
        end
        // Without stop-on-fault only the faulty transistor drops out
        next_q.fet_off = q.fet_off & ~pwm_on_start; // R12
        if (!stop_en) begin
            next_q.fet_off = next_q.fet_off | sb_fault; // R11
        end

        // Overtemperature; ignored without stop-on-fault
        ot_active = stop_en & over_temp; // R10 R7
        if (over_temp || ot_tif.done) begin
            next_q.ot_hold = 1'b0;
        end else if (stop_en && q.ot_d) begin
            next_q.ot_hold = 1'b1; // R9
        end

        // Regulator and watchdog faults latch until watchdog activity after the window timer is done
        crit_now = logic_regulator_uv | watchdog_fault;
        wd_edge  = watchdog_in ^ q.wd_d;
        if (wd_tif.done && wd_edge) begin
            next_q.crit_lat = 1'b0; // R15
        end
        if (crit_now) begin
            next_q.crit_lat = 1'b1; // R15
        end
        next_q.host_reset_out_n    = ~(crit_now | ot_active | next_q.ot_hold); // R15 R16
        next_q.logic_regulator_off = ot_active | next_q.ot_hold;               // R16

        // Sticky flags, set wins over a read clear
        next_q.st_flags    = (rd_clr_st ? '0 : q.st_flags)
                           | status_events(main_supply_uv, logic_regulator_uv,
                                           watchdog_fault, over_temp, sync_loss); // R18
        next_q.short_flags = sticky_fet(q.short_flags, rd_clr_dg, drain_source_monitor); // R18
        next_q.boot_flags  = sticky_fet(q.boot_flags, rd_clr_dg, bootstrap_uv);          // R18

        full_off = (stop_en & main_supply_uv) | next_q.main_uv_lat | sync_loss
                 | next_q.sync_lat | crit_now | next_q.crit_lat | ot_active
                 | next_q.ot_hold | (|next_q.sb_lat); // R20 R2 R7
        next_q.gate_disable = full_off;
        if (full_off || !next_q.ctrl[CTRL_RUN]) begin
            next_q.gate = '0; // R13
        end else begin
            next_q.gate = gate_cmd & ~next_q.fet_off; // R11
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            // Power-on reset drops every latch and flag
            q                  <= '0; // R17
            q.ctrl             <= CTRL_RST;
            q.host_reset_out_n <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    assign wb_ack_o            = q.wb_ack;
    assign wb_dat_o            = q.wb_dat;
    assign gate_out            = q.gate;
    assign gate_disable        = q.gate_disable;
    assign host_reset_out_n    = q.host_reset_out_n;
    assign logic_regulator_off = q.logic_regulator_off;
    assign restart_req         = q.restart_req;
endmodule
`default_nettype wire

// *** inc/mfr_pkg.sv ***
// Package: constants, register map and state types for the fault response controller
package mfr_pkg;

    // Clock and fault timing
    localparam int CLK_MHZ        = 250;
    localparam int OT_HOLD_MS     = 10;
    localparam int WD_WINDOW_MS   = 100;
    localparam int OT_HOLD_CYC    = OT_HOLD_MS * 1000 * CLK_MHZ;
    localparam int WD_WINDOW_CYC  = WD_WINDOW_MS * 1000 * CLK_MHZ;
    localparam int TMR_W          = 32;

    // Bus geometry
    localparam int ADR_W          = 4;
    localparam int DAT_W          = 32;
    localparam int NUM_FET        = 6;
    localparam int DEMAND_W       = 8;

    // Register byte offsets
    localparam logic [ADR_W-1:0] ADR_CTRL   = 4'h0;
    localparam logic [ADR_W-1:0] ADR_STATUS = 4'h4;
    localparam logic [ADR_W-1:0] ADR_DIAG   = 4'h8;
    localparam logic [ADR_W-1:0] ADR_STATE  = 4'hC;

    // Control register fields
    localparam int CTRL_STOP_EN   = 0;
    localparam int CTRL_RESTART   = 1;
    localparam int CTRL_RUN       = 2;
    localparam int CTRL_INH       = 3;
    localparam int CTRL_W         = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

    // Status register fields
    localparam int ST_MAIN_UV     = 0;
    localparam int ST_LR_UV       = 1;
    localparam int ST_WD          = 2;
    localparam int ST_OT          = 3;
    localparam int ST_SYNC        = 4;
    localparam int ST_W           = 5;

    // Diagnostic register fields: shorts in low byte, bootstrap in next
    localparam int DG_SHORT_LSB   = 0;
    localparam int DG_BOOT_LSB    = 8;

    typedef struct packed {
        logic [CTRL_W-1:0]    ctrl;
        logic                 wb_ack;
        logic [DAT_W-1:0]     wb_dat;
        logic [ST_W-1:0]      st_flags;
        logic [NUM_FET-1:0]   short_flags;
        logic [NUM_FET-1:0]   boot_flags;
        logic                 main_uv_lat;
        logic                 sync_lat;
        logic                 crit_lat;
        logic                 ot_hold;
        logic [NUM_FET-1:0]   sb_lat;
        logic [NUM_FET-1:0]   fet_off;
        logic                 demand_zero_seen;
        logic                 main_uv_d;
        logic                 sync_d;
        logic                 ot_d;
        logic                 wd_d;
        logic [NUM_FET-1:0]   gate;
        logic                 gate_disable;
        logic                 host_reset_out_n;
        logic                 logic_regulator_off;
        logic                 restart_req;
    } mfr_state_t;

    typedef struct packed {
        logic [TMR_W-1:0] count;
        logic             done;
    } mfr_tmr_state_t;

endpackage

// *** inc/mfr_tmr_if.sv ***
// Interface between the controller and one hold timer
`timescale 1ns/10ps
`default_nettype none
interface mfr_tmr_if;
    logic run;
    logic done;
    modport ctrl (output run, input done);
    modport tmr  (input run, output done);
endinterface
`default_nettype wire

// *** verilog/mfr_timer.sv ***
// Hold timer: counts while run is high, done stays high once limit is reached
`timescale 1ns/10ps
`default_nettype none
module mfr_timer #(
    parameter logic [mfr_pkg::TMR_W-1:0] LIMIT = 32'h0000_0010
) (
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  rstn,
    // Control side
    mfr_tmr_if.tmr     tif
);
    import mfr_pkg::*;

    mfr_tmr_state_t q;
    mfr_tmr_state_t next_q;

    always_comb begin
        next_q = q;
        if (!tif.run) begin
            // Dropping run restarts the count from zero
            next_q.count = '0;
            next_q.done  = 1'b0;
        end else if (!q.done) begin
            next_q.count = q.count + 1'b1;
            next_q.done  = (q.count + 1'b1 >= LIMIT);
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign tif.done = q.done;
endmodule
`default_nettype wire

// *** dv/mfr_ctrl_props.sv ***
// Checker: port-level timing properties of the fault response controller
`timescale 1ns/10ps
`default_nettype none
module mfr_ctrl_props (
    // Clock and reset
    input wire logic                        clock,
    input wire logic                        rstn,
    // Register bus
    input wire logic                        wb_cyc_i,
    input wire logic                        wb_stb_i,
    input wire logic                        wb_we_i,
    input wire logic [mfr_pkg::ADR_W-1:0]   wb_adr_i,
    input wire logic                        wb_ack_o,
    input wire logic [mfr_pkg::DAT_W-1:0]   wb_dat_o,
    // Faults and drive outputs
    input wire logic                        logic_regulator_uv,
    input wire logic                        watchdog_fault,
    input wire logic [mfr_pkg::NUM_FET-1:0] drain_source_monitor,
    input wire logic [mfr_pkg::NUM_FET-1:0] bootstrap_uv,
    input wire logic [mfr_pkg::NUM_FET-1:0] gate_out,
    input wire logic                        gate_disable,
    input wire logic                        host_reset_out_n
);
    import mfr_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
    // Holes in the map read as zero
    property p_hole; wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == '0; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_full_off; gate_disable |-> gate_out == '0; endproperty
    a_full_off: assert property (p_full_off) else $error("gate on during disable");
    property p_short_off;
        |drain_source_monitor |=> (gate_out & $past(drain_source_monitor)) == '0; endproperty
    a_short_off: assert property (p_short_off) else $error("shorted gate on");
    property p_boot_off;
        |bootstrap_uv |=> (gate_out & $past(bootstrap_uv)) == '0; endproperty
    a_boot_off: assert property (p_boot_off) else $error("low bootstrap gate on");
    property p_crit;
        logic_regulator_uv || watchdog_fault |=> !host_reset_out_n && gate_disable; endproperty
    a_crit: assert property (p_crit) else $error("critical fault not acted on");
    // Latch must outlive the fault itself
    property p_crit_latch; $fell(watchdog_fault) |-> gate_disable [*3]; endproperty
    a_crit_latch: assert property (p_crit_latch) else $error("critical latch lost");
endmodule
bind mfr_ctrl mfr_ctrl_props u_props (
    .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .logic_regulator_uv(logic_regulator_uv), .watchdog_fault(watchdog_fault),
    .drain_source_monitor(drain_source_monitor), .bootstrap_uv(bootstrap_uv),
    .gate_out(gate_out), .gate_disable(gate_disable), .host_reset_out_n(host_reset_out_n));
`default_nettype wire

// *** dv/mfr_host_model.sv ***
// Host model: speed demand and watchdog pin behaviour
`timescale 1ns/10ps
`default_nettype none
module mfr_host_model (
    // Clock and reset
    input wire logic  clock,
    input wire logic  rstn,
    // Requests from the bench
    input wire logic  demand_reset,
    input wire logic  wd_toggle,
    // Pins toward the controller
    output logic [7:0] speed_demand,
    output logic       watchdog_in
);
    logic zero_phase;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            speed_demand <= 8'h40;
            watchdog_in <= 1'b0;
            zero_phase <= 1'b0;
        end else begin
            if (wd_toggle) begin
                watchdog_in <= !watchdog_in;
            end
            // Zero first, then a fresh operating value
            if (demand_reset) begin
                speed_demand <= 8'h00;
                zero_phase <= 1'b1;
            end else if (zero_phase) begin
                speed_demand <= 8'h41;
                zero_phase <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Testbench: random and corner-case runs of the fault response controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mfr_pkg::*;
    logic             clock, rstn, cyc, stb, we, ack, hro, gd, lro, rreq, dreq, wtog, wdin;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [DAT_W-1:0] wdat, rdat, wbo;
    logic [16:0]      fv;
    logic [5:0]       gcmd, pon, gout;
    logic [7:0]       dem;
    int               fails, n_checks, seed, k, b;

    mfr_ctrl #(.OT_HOLD_CYCLES(32'h0000_0014), .WD_WINDOW_CYCLES(32'h0000_001E)) DUT (
        .clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(wbo),
        .main_supply_uv(fv[0]), .logic_regulator_uv(fv[1]), .watchdog_fault(fv[2]),
        .over_temp(fv[3]), .sync_loss(fv[4]), .drain_source_monitor(fv[10:5]),
        .bootstrap_uv(fv[16:11]), .speed_demand(dem), .watchdog_in(wdin),
        .host_reset_out_n(hro), .gate_cmd(gcmd), .pwm_on_start(pon), .gate_out(gout),
        .gate_disable(gd), .logic_regulator_off(lro), .restart_req(rreq));
    mfr_host_model HOST (.clock(clock), .rstn(rstn), .demand_reset(dreq),
        .wd_toggle(wtog), .speed_demand(dem), .watchdog_in(wdin));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    function automatic logic [5:0] exp_g(input logic [5:0] off);
        return gcmd & ~off;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wb(input logic wr, input logic [ADR_W-1:0] a, input logic [3:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        wdat <= 32'(d);
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t bus request not answered", $time);
            tally_and_finish();
        end
        rdat = wbo;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clock);
    endtask
    task automatic pulse(input logic [16:0] v);
        fv <= v;
        w(2);
        fv <= 17'h0_0000;
        w(3);
    endtask
    task automatic tog();
        wtog <= 1'b1;
        w(1);
        wtog <= 1'b0;
        w(3);
    endtask
    task automatic count_req();
        k = 0;
        repeat (6) begin
            @(posedge clock);
            if (rreq === 1'b1) k++;
        end
    endtask

    initial begin
        seed = 47;
        {rstn, cyc, stb, we, dreq, wtog} = 6'h00;
        {adr, wdat, fv, pon, gcmd, sel} = '0;
        w(4);
        rstn <= 1'b1;
        gcmd <= 6'($random(seed));
        b = int'($unsigned($random(seed)) % 6);
        w(1);
        wb(1'b0, ADR_CTRL, 4'h0);
        chk(rdat, 32'h0000_0000);
        wb(1'b0, 4'h2, 4'h0);
        chk(rdat, 32'h0000_0000);
        wb(1'b1, ADR_CTRL, 4'h5);
        wb(1'b0, ADR_CTRL, 4'h0);
        chk(rdat, 32'h0000_0000);
        sel <= 4'hF;
        wb(1'b1, ADR_CTRL, 4'h5);
        wb(1'b0, ADR_CTRL, 4'h0);
        chk(rdat, 32'h0000_0005);
        chk(32'(gout), 32'(exp_g(6'h00)));
        $display("test registers done");
        fv <= 17'h0_0008;
        w(3);
        chk(32'({gout, gd, hro, lro}), 32'h0000_0005);
        fv <= 17'h0_0000;
        w(12);
        chk(32'(gd), 32'h0000_0001);
        w(14);
        chk(32'({gout, gd, hro, lro}), 32'({exp_g(6'h00), 3'b010}));
        wb(1'b0, ADR_STATUS, 4'h0);
        chk(rdat, 32'(1 << ST_OT));
        wb(1'b0, ADR_STATUS, 4'h0);
        chk(rdat, 32'h0000_0000);
        $display("test overtemperature done");
        pulse({6'h00, 6'(1 << b), 5'h00});
        chk(32'({gout, gd}), 32'h0000_0001);
        wb(1'b1, ADR_CTRL, 4'hD);
        wb(1'b0, ADR_DIAG, 4'h0);
        chk(rdat, 32'(1 << b));
        chk(32'(gd), 32'h0000_0001);
        wb(1'b1, ADR_CTRL, 4'h5);
        wb(1'b0, ADR_DIAG, 4'h0);
        w(2);
        chk(32'({gout, gd}), 32'({exp_g(6'h00), 1'b0}));
        pulse({6'(1 << b), 11'h000});
        chk(32'(gd), 32'h0000_0001);
        dreq <= 1'b1;
        w(1);
        dreq <= 1'b0;
        w(4);
        chk(32'({gout, gd}), 32'({exp_g(6'h00), 1'b0}));
        pulse({6'h00, 6'(1 << b), 5'h00});
        wb(1'b1, ADR_CTRL, 4'h1);
        wb(1'b1, ADR_CTRL, 4'h5);
        w(2);
        chk(32'({gout, gd}), 32'({exp_g(6'h00), 1'b0}));
        wb(1'b1, ADR_CTRL, 4'h4);
        pulse({6'h00, 6'(1 << b), 5'h00});
        chk(32'({gout, gd}), 32'({exp_g(6'(1 << b)), 1'b0}));
        wb(1'b0, ADR_STATE, 4'h0);
        chk(rdat, 32'h0001_0000 | (32'h0000_0040 << b));
        pon <= 6'(1 << b);
        w(1);
        pon <= 6'h00;
        w(3);
        chk(32'(gout), 32'(exp_g(6'h00)));
        fv <= 17'h0_0009;
        w(3);
        chk(32'({gout, gd, hro}), 32'({exp_g(6'h00), 2'b01}));
        fv <= 17'h0_0000;
        wb(1'b0, ADR_STATUS, 4'h0);
        $display("test short faults done");
        wb(1'b1, ADR_CTRL, 4'h7);
        fv <= 17'h0_0001;
        w(3);
        chk(32'(gout), 32'h0000_0000);
        fv <= 17'h0_0000;
        count_req();
        chk(32'(k), 32'h0000_0001);
        chk(32'(gout), 32'(exp_g(6'h00)));
        wb(1'b1, ADR_CTRL, 4'h5);
        pulse(17'h0_0001);
        chk(32'(gout), 32'h0000_0000);
        wb(1'b0, ADR_STATUS, 4'h0);
        w(2);
        chk(32'(gout), 32'(exp_g(6'h00)));
        wb(1'b1, ADR_CTRL, 4'h7);
        fv <= 17'h0_0010;
        w(1);
        fv <= 17'h0_0000;
        count_req();
        chk(32'(k), 32'h0000_0001);
        $display("test supply and sync done");
        fv <= 17'h0_0004;
        w(3);
        chk(32'({gd, hro}), 32'h0000_0002);
        fv <= 17'h0_0000;
        w(5);
        tog();
        chk(32'(gd), 32'h0000_0001);
        w(40);
        tog();
        chk(32'(gd), 32'h0000_0000);
        fv <= 17'h0_0002;
        w(2);
        rstn <= 1'b0;
        fv <= 17'h0_0000;
        w(4);
        rstn <= 1'b1;
        w(2);
        chk(32'({gd, hro}), 32'h0000_0001);
        wb(1'b0, ADR_CTRL, 4'h0);
        chk(rdat, 32'h0000_0000);
        $display("test watchdog and reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
